// ---- rtl/dst_match.sv ----
`timescale 1ns/1ps
`include "rtc_dst_params.svh"
module dst_match
   import rtc_dst_pkg::*;
(
   input  wire dst_sched_t sched,
   input  wire clock_now_t now,
   input  wire logic       hour_24_select,
   output logic            hit
);
   wire       weekday_select = sched.day_week[`BIT_WEEKDAY_SELECT];
   wire [2:0] want_day       = sched.day_week[2:0];
   wire [2:0] want_week      = sched.day_week[5:3];
   wire       week_ok        = (want_week == `WEEK_LAST) ? now.last_week
                                : (want_week == now.week_of_month);
   wire       dw_ok          = week_ok && (want_day == now.weekday);
   wire       date_ok        = (sched.date[5:0] == now.date[5:0]);
   // Hour compared as if the 24-hour bit matched the clock's own
   wire [7:0] want_hour      = {hour_24_select, 1'b0, sched.hour[5:0]};
   wire       hour_ok        = (want_hour == now.hours);
   wire       month_ok       = (sched.month[4:0] == now.month[4:0]);
   assign hit = month_ok && hour_ok && (weekday_select ? dw_ok : date_ok);
endmodule

// ---- rtl/rtc_dst_events.sv ----
`timescale 1ns/1ps
`include "rtc_dst_params.svh"
// Operation
// - Periodic mode sets flag every match, no clear
// - Main-to-battery stamp keeps first switchover only
// - Stamp holds seconds to month, no year
// - Stamp clear bit at 09h clears both
// - Cleared stamp reads all zeros
// - Battery-to-main stamp overwritten every switchover
// - Bit 7 of 20h enables, resets zero
// - Enable low forces adjusted flag zero
// - Forward month uses clock encoding, resets 00h
// - Reverse month resets to October 10h
// - Weekday bits 2:0, week bits 5:3
// - Bit 6 selects weekday/week matching
// - Date fields used only when select zero
// - Hour compared with clock's 24-hour setting
// - Eight schedule registers at 20h to 27h
// - Single-event flag holds irq until cleared
module rtc_dst_events
   import rtc_dst_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       auto_clear_on_read_n,
   input  wire logic       clk_en,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire clock_now_t clock_now,
   input  wire logic       hour_24_select,
   input  wire logic       alarm_match,
   input  wire logic       periodic_alarm_select,
   input  wire logic       auto_clear_on_read,
   input  wire logic       status_read,
   input  wire logic       switch_to_batt,
   input  wire logic       switch_to_main,
   output logic            hour_inc,
   output logic            hour_dec,
   output logic            alarm_flag,
   output logic            dst_adjusted_flag,
   output logic            irq_or_freq_out_n
);
   dst_sched_t fwd_reg;
   dst_sched_t rev_reg;
   logic       dst_enable_reg;
   logic       adjusted_reg;
   logic       alarm_reg;
   logic       pulse_reg;
   logic       fwd_done_reg;
   logic       rev_done_reg;
   logic [7:0] rdata_reg;
   stamp_t     m2b_rec;
   stamp_t     b2m_rec;
   logic       fwd_hit;
   logic       rev_hit;
   wire stamp_t now_stamp = {clock_now.seconds, clock_now.minutes, clock_now.hours,
                             clock_now.date, clock_now.month};
   wire wr_fm   = reg_wr && (reg_addr == `OFS_FWD_MONTH);
   wire wr_fdw  = reg_wr && (reg_addr == `OFS_FWD_DAY_WEEK);
   wire wr_fdt  = reg_wr && (reg_addr == `OFS_FWD_DATE);
   wire wr_fhr  = reg_wr && (reg_addr == `OFS_FWD_HOUR);
   wire wr_rm   = reg_wr && (reg_addr == `OFS_REV_MONTH);
   wire wr_rdw  = reg_wr && (reg_addr == `OFS_REV_DAY_WEEK);
   wire wr_rdt  = reg_wr && (reg_addr == `OFS_REV_DATE);
   wire wr_rhr  = reg_wr && (reg_addr == `OFS_REV_HOUR);
   wire wr_pwr  = reg_wr && (reg_addr == `OFS_PWR_CTRL);
   wire wr_stat = reg_wr && (reg_addr == `OFS_DST_STATUS);
   wire stamp_clear = wr_pwr && reg_wdata[`BIT_STAMP_CLEAR];
   wire alarm_sw_clear = (wr_stat && !reg_wdata[`BIT_ALARM_FLAG])
                         || (status_read && auto_clear_on_read);
   wire fwd_fire = dst_enable_reg && fwd_hit && !fwd_done_reg && !adjusted_reg;
   wire rev_fire = dst_enable_reg && rev_hit && !rev_done_reg && adjusted_reg;
   wire [2:0] stamp_idx_m2b = 3'(reg_addr - `OFS_STAMP_M2B);
   wire [2:0] stamp_idx_b2m = 3'(reg_addr - `OFS_STAMP_B2M);
   wire in_m2b = (reg_addr >= `OFS_STAMP_M2B) && (reg_addr < `OFS_STAMP_B2M);
   wire in_b2m = (reg_addr >= `OFS_STAMP_B2M) && (reg_addr < `OFS_DST_STATUS);
   logic [7:0] rd_mux;
   function automatic logic [7:0] stamp_byte(stamp_t s, logic [2:0] i);
      logic [7:0] b;
      b = 8'h00;
      unique case (i)
         3'h0: b = s.seconds;
         3'h1: b = s.minutes;
         3'h2: b = s.hours;
         3'h3: b = s.date;
         3'h4: b = s.month;
         default: b = 8'h00;
      endcase
      return b;
   endfunction
   always_comb begin
      rd_mux = 8'h00;
      if (in_m2b) begin
         rd_mux = stamp_byte(m2b_rec, stamp_idx_m2b);
      end else if (in_b2m) begin
         rd_mux = stamp_byte(b2m_rec, stamp_idx_b2m);
      end else begin
         unique case (reg_addr)
            `OFS_FWD_MONTH:    rd_mux = {dst_enable_reg, 2'b00, fwd_reg.month[4:0]};
            `OFS_FWD_DAY_WEEK: rd_mux = {1'b0, fwd_reg.day_week[6:0]};
            `OFS_FWD_DATE:     rd_mux = {2'b00, fwd_reg.date[5:0]};
            `OFS_FWD_HOUR:     rd_mux = {2'b00, fwd_reg.hour[5:0]};
            `OFS_REV_MONTH:    rd_mux = {3'b000, rev_reg.month[4:0]};
            `OFS_REV_DAY_WEEK: rd_mux = {1'b0, rev_reg.day_week[6:0]};
            `OFS_REV_DATE:     rd_mux = {2'b00, rev_reg.date[5:0]};
            `OFS_REV_HOUR:     rd_mux = {2'b00, rev_reg.hour[5:0]};
            `OFS_DST_STATUS:   rd_mux = {6'h00, adjusted_reg, alarm_reg};
            default:           rd_mux = 8'h00;
         endcase
      end
   end
   dst_match u_fwd (
      .sched          (fwd_reg),
      .now            (clock_now),
      .hour_24_select (hour_24_select),
      .hit            (fwd_hit)
   );
   dst_match u_rev (
      .sched          (rev_reg),
      .now            (clock_now),
      .hour_24_select (hour_24_select),
      .hit            (rev_hit)
   );
   stamp_record #(.FIRST_ONLY(1'b1)) u_m2b (
      .sys_clk (sys_clk),
      .auto_clear_on_read_n  (auto_clear_on_read_n),
      .clk_en  (clk_en),
      .trigger (switch_to_batt),
      .clear   (stamp_clear),
      .now     (now_stamp),
      .record  (m2b_rec)
   );
   stamp_record #(.FIRST_ONLY(1'b0)) u_b2m (
      .sys_clk (sys_clk),
      .auto_clear_on_read_n  (auto_clear_on_read_n),
      .clk_en  (clk_en),
      .trigger (switch_to_main),
      .clear   (stamp_clear),
      .now     (now_stamp),
      .record  (b2m_rec)
   );
   always_ff @(posedge sys_clk or negedge auto_clear_on_read_n) begin
      if (!auto_clear_on_read_n) begin
         fwd_reg        <= {`RST_FWD_MONTH, `RST_DAY_WEEK, `RST_DATE, `RST_HOUR};
         rev_reg        <= {`RST_REV_MONTH, `RST_DAY_WEEK, `RST_DATE, `RST_HOUR};
         dst_enable_reg <= 1'b0;
      end else if (clk_en) begin
         if (wr_fm) begin
            fwd_reg.month  <= {3'b000, reg_wdata[4:0]};
            dst_enable_reg <= reg_wdata[`BIT_DST_ENABLE];
         end
         if (wr_fdw) fwd_reg.day_week <= {1'b0, reg_wdata[6:0]};
         if (wr_fdt) fwd_reg.date <= {2'b00, reg_wdata[5:0]};
         if (wr_fhr) fwd_reg.hour <= {2'b00, reg_wdata[5:0]};
         if (wr_rm) rev_reg.month <= {3'b000, reg_wdata[4:0]};
         if (wr_rdw) rev_reg.day_week <= {1'b0, reg_wdata[6:0]};
         if (wr_rdt) rev_reg.date <= {2'b00, reg_wdata[5:0]};
         if (wr_rhr) rev_reg.hour <= {2'b00, reg_wdata[5:0]};
      end
   end
   // Done flags stop a second step while the schedule hour still matches
   always_ff @(posedge sys_clk or negedge auto_clear_on_read_n) begin
      if (!auto_clear_on_read_n) begin
         adjusted_reg <= 1'b0;
         fwd_done_reg <= 1'b0;
         rev_done_reg <= 1'b0;
      end else if (clk_en) begin
         fwd_done_reg <= fwd_hit && (fwd_done_reg || fwd_fire);
         rev_done_reg <= rev_hit && (rev_done_reg || rev_fire);
         if (!dst_enable_reg) adjusted_reg <= 1'b0;
         else if (fwd_fire) adjusted_reg <= 1'b1;
         else if (rev_fire) adjusted_reg <= 1'b0;
      end
   end
   // Set wins over clear on the same cycle
   always_ff @(posedge sys_clk or negedge auto_clear_on_read_n) begin
      if (!auto_clear_on_read_n) begin
         alarm_reg <= 1'b0;
         pulse_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else if (clk_en) begin
         pulse_reg <= alarm_match && periodic_alarm_select;
         if (alarm_match) alarm_reg <= 1'b1;
         else if (alarm_sw_clear) alarm_reg <= 1'b0;
         if (reg_rd) rdata_reg <= rd_mux;
      end
   end
   assign hour_inc          = fwd_fire && clk_en;
   assign hour_dec          = rev_fire && clk_en;
   assign alarm_flag        = alarm_reg;
   assign dst_adjusted_flag = adjusted_reg && dst_enable_reg;
   // Periodic mode pulses one cycle; flag state does not gate it
   assign irq_or_freq_out_n = periodic_alarm_select ? !pulse_reg : !alarm_reg;
   assign reg_rdata         = rdata_reg;
endmodule

// ---- rtl/rtc_dst_params.svh ----
`ifndef RTC_DST_PARAMS_SVH
`define RTC_DST_PARAMS_SVH
`define OFS_PWR_CTRL       8'h09
`define OFS_FWD_MONTH      8'h20
`define OFS_FWD_DAY_WEEK   8'h21
`define OFS_FWD_DATE       8'h22
`define OFS_FWD_HOUR       8'h23
`define OFS_REV_MONTH      8'h24
`define OFS_REV_DAY_WEEK   8'h25
`define OFS_REV_DATE       8'h26
`define OFS_REV_HOUR       8'h27
`define OFS_STAMP_M2B      8'h30
`define OFS_STAMP_B2M      8'h35
`define OFS_DST_STATUS     8'h3A
`define RST_FWD_MONTH      8'h00
`define RST_REV_MONTH      8'h10
`define RST_DAY_WEEK       8'h00
`define RST_DATE           8'h00
`define RST_HOUR           8'h00
`define BIT_DST_ENABLE     7
`define BIT_WEEKDAY_SELECT 6
`define BIT_STAMP_CLEAR    0
`define BIT_ALARM_FLAG     0
`define BIT_DST_ADJUSTED   1
`define WEEK_LAST          3'h7
`endif

// ---- rtl/rtc_dst_pkg.sv ----
package rtc_dst_pkg;
   typedef struct packed {
      logic [7:0] seconds;
      logic [7:0] minutes;
      logic [7:0] hours;
      logic [7:0] date;
      logic [7:0] month;
   } stamp_t;
   typedef struct packed {
      logic [7:0] month;
      logic [7:0] day_week;
      logic [7:0] date;
      logic [7:0] hour;
   } dst_sched_t;
   typedef struct packed {
      logic [7:0] seconds;
      logic [7:0] minutes;
      logic [7:0] hours;
      logic [7:0] date;
      logic [7:0] month;
      logic [2:0] weekday;
      logic [2:0] week_of_month;
      logic       last_week;
   } clock_now_t;
endpackage

// ---- rtl/stamp_record.sv ----
`timescale 1ns/1ps
`include "rtc_dst_params.svh"
module stamp_record
   import rtc_dst_pkg::*;
#(
   parameter bit FIRST_ONLY = 1'b1
) (
   input  wire logic   sys_clk,
   input  wire logic   auto_clear_on_read_n,
   input  wire logic   clk_en,
   input  wire logic   trigger,
   input  wire logic   clear,
   input  wire stamp_t now,
   output stamp_t      record
);
   logic captured_reg;
   wire  take = trigger && !(FIRST_ONLY && captured_reg);
   always_ff @(posedge sys_clk or negedge auto_clear_on_read_n) begin
      if (!auto_clear_on_read_n) begin
         record       <= '0;
         captured_reg <= 1'b0;
      end else if (clk_en) begin
         if (take) begin
            // Capture beats clear, but a FIRST_ONLY record already held loses a same-cycle switchover to clear
            record       <= now;
            captured_reg <= 1'b1;
         end else if (clear) begin
            record       <= '0;
            captured_reg <= 1'b0;
         end
      end
   end
endmodule

// ---- verif/host_bus.sv ----
`timescale 1ns/1ps
module host_bus (
   input  wire logic       sys_clk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'hFF;
      reg_wdata = 8'h00;
   end
   // Released bus shows junk, not the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule

// ---- verif/rtc_dst_checker.sv ----
`timescale 1ns/1ps
module rtc_dst_checker
   import rtc_dst_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       auto_clear_on_read_n,
   input wire logic       clk_en,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       alarm_match,
   input wire logic       periodic_alarm_select,
   input wire logic       status_read,
   input wire logic       hour_inc,
   input wire logic       hour_dec,
   input wire logic       alarm_flag,
   input wire logic       dst_adjusted_flag,
   input wire logic       irq_or_freq_out_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!auto_clear_on_read_n);
   wire single = !periodic_alarm_select;
   property p_periodic;
      clk_en && alarm_match && periodic_alarm_select |=> alarm_flag;
   endproperty
   property p_hold;
      single && alarm_flag && !reg_wr && !status_read |=> alarm_flag;
   endproperty
   property p_irq_low;
      single && alarm_flag && $past(alarm_flag) && !$past(periodic_alarm_select)
         |-> !irq_or_freq_out_n;
   endproperty
   property p_inc_sets;
      clk_en && hour_inc |=> dst_adjusted_flag && !hour_inc;
   endproperty
   property p_dec_clears;
      clk_en && hour_dec |=> !dst_adjusted_flag;
   endproperty
   property p_inc_needs_clear;
      hour_inc |-> !dst_adjusted_flag && !hour_dec;
   endproperty
   property p_dec_needs_set;
      hour_dec |-> dst_adjusted_flag;
   endproperty
   property p_rdata_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_periodic: assert property (p_periodic) else $error("flag missed");
   a_hold: assert property (p_hold) else $error("flag dropped");
   a_irq_low: assert property (p_irq_low) else $error("irq not low");
   a_inc_sets: assert property (p_inc_sets) else $error("inc bad");
   a_dec_clears: assert property (p_dec_clears) else $error("dec bad");
   a_inc_needs_clear: assert property (p_inc_needs_clear) else $error("inc twice");
   a_dec_needs_set: assert property (p_dec_needs_set) else $error("dec early");
   a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
   c_inc: cover property (hour_inc);
   c_dec: cover property (hour_dec);
   c_single: cover property (single && alarm_flag);
endmodule
bind rtc_dst_events rtc_dst_checker chk (.sys_clk(sys_clk), .auto_clear_on_read_n(auto_clear_on_read_n),
   .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .alarm_match(alarm_match), .periodic_alarm_select(periodic_alarm_select),
   .status_read(status_read), .hour_inc(hour_inc), .hour_dec(hour_dec),
   .alarm_flag(alarm_flag), .dst_adjusted_flag(dst_adjusted_flag),
   .irq_or_freq_out_n(irq_or_freq_out_n));

// ---- verif/rtc_dst_events_bench.sv ----
`timescale 1ns/1ps
module rtc_dst_events_bench
   import rtc_dst_pkg::*;
;
   logic       sys_clk = 1'b0;
   logic       auto_clear_on_read_n = 1'b0;
   logic       reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   clock_now_t clock_now = '{8'h00, 8'h00, 8'h81, 8'h01, 8'h01, 3'h1, 3'h1, 1'b0};
   logic       h24 = 1'b1, match = 1'b0, per = 1'b0, acr = 1'b0, sread = 1'b0;
   logic       to_batt = 1'b0, to_main = 1'b0, inc, dec, flag, adj, irq_n;
   int         n_errors = 0, num_checks = 0;
   clock_now_t ta = '{8'h15, 8'h42, 8'h82, 8'h0A, 8'h03, 3'h2, 3'h2, 1'b0};
   clock_now_t tb = '{8'h59, 8'h07, 8'h93, 8'h1C, 8'h11, 3'h5, 3'h4, 1'b0};
   clock_now_t tr = '{8'h30, 8'h10, 8'h82, 8'h1F, 8'h10, 3'h0, 3'h4, 1'b1};
   logic [7:0] rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
   always #12.5 sys_clk = ~sys_clk;
   host_bus host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   rtc_dst_events DUT (.sys_clk(sys_clk), .auto_clear_on_read_n(auto_clear_on_read_n), .clk_en(1'b1),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .clock_now(clock_now), .hour_24_select(h24),
      .alarm_match(match), .periodic_alarm_select(per), .auto_clear_on_read(acr),
      .status_read(sread), .switch_to_batt(to_batt), .switch_to_main(to_main),
      .hour_inc(inc), .hour_dec(dec), .alarm_flag(flag), .dst_adjusted_flag(adj),
      .irq_or_freq_out_n(irq_n));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic chk_stamp(input logic [7:0] base, input logic [39:0] e);
      logic [7:0] v;
      for (int i = 0; i < 5; i++) begin
         host.rd(base + 8'(i), v);
         check("stamp", v, e[39 - 8 * i -: 8]);
      end
   endtask
   function automatic logic [39:0] st(input clock_now_t c);
      return {c.seconds, c.minutes, c.hours, c.date, c.month};
   endfunction
   task automatic pulse_batt(input logic main);
      @(negedge sys_clk);
      if (main) to_main = 1'b1; else to_batt = 1'b1;
      @(negedge sys_clk);
      to_main = 1'b0;
      to_batt = 1'b0;
   endtask
   task automatic pulse_alarm();
      @(negedge sys_clk);
      match = 1'b1;
      @(negedge sys_clk);
      match = 1'b0;
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Whole run is well under a thousand cycles
   initial begin
      #100000;
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (10) @(negedge sys_clk);
      auto_clear_on_read_n = 1'b1;
      for (int i = 0; i < 8; i++) begin
         host.rd(8'h20 + 8'(i), d);
         check("sched reset", d, rst_val[i]);
      end
      host.rd(8'h41, d);
      check("unmapped", d, 8'h00);
      $display("test reset done");
      clock_now = ta;
      pulse_batt(1'b0);
      chk_stamp(8'h30, st(ta));
      clock_now = tb;
      pulse_batt(1'b0);
      chk_stamp(8'h30, st(ta));
      pulse_batt(1'b1);
      chk_stamp(8'h35, st(tb));
      clock_now = ta;
      pulse_batt(1'b1);
      chk_stamp(8'h35, st(ta));
      host.wr(8'h09, 8'h01);
      chk_stamp(8'h30, 40'h0);
      chk_stamp(8'h35, 40'h0);
      $display("test stamps done");
      clock_now = tb;
      host.wr(8'h20, 8'h83);
      host.wr(8'h22, 8'h0A);
      host.wr(8'h23, 8'h02);
      host.wr(8'h25, 8'h78);
      host.wr(8'h27, 8'h02);
      host.rd(8'h20, d);
      check("enable", d, 8'h83);
      for (int k = 0; k < 3; k++) begin
         @(negedge sys_clk);
         clock_now = k == 1 ? tr : ta;
         #1;
         check("step", k == 1 ? dec : inc, 1'b1);
         @(negedge sys_clk);
         check("adjusted", adj, k == 1 ? 1'b0 : 1'b1);
      end
      host.rd(8'h3A, d);
      check("status", d, 8'h02);
      host.wr(8'h20, 8'h03);
      @(negedge sys_clk);
      check("forced", adj, 1'b0);
      $display("test dst done");
      per = 1'b1;
      repeat (2) begin
         pulse_alarm();
         check("periodic", flag, 1'b1);
         check("periodic irq", irq_n, 1'b0);
         @(negedge sys_clk);
         check("periodic irq end", irq_n, 1'b1);
      end
      per = 1'b0;
      host.wr(8'h3A, 8'h00);
      pulse_alarm();
      repeat (2) @(negedge sys_clk);
      check("single", flag, 1'b1);
      check("irq", irq_n, 1'b0);
      host.wr(8'h3A, 8'h00);
      repeat (2) @(negedge sys_clk);
      check("cleared", flag, 1'b0);
      check("irq off", irq_n, 1'b1);
      acr = 1'b1;
      pulse_alarm();
      sread = 1'b1;
      @(negedge sys_clk);
      sread = 1'b0;
      @(negedge sys_clk);
      check("auto", flag, 1'b0);
      $display("test alarm done");
      finish_test();
   end
endmodule
